// >>> core/sar_consts.svh
// Shared constants of the successive-approximation register
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH
`define SAR_WIDTH_SHORT 8
`define SAR_WIDTH_LONG  12
`define SAR_BUF_DEPTH   2
`define SAR_PIN_COUNT   3
`define SAR_PIN_START   0
`define SAR_PIN_DATA    1
`define SAR_PIN_EXPAND  2
`define SAR_PIN_IDLE    3'h1
`define SAR_BOTTOM      0
`endif

// >>> core/sar_pkg.sv
// Types shared by the successive-approximation register design
`include "sar_consts.svh"
package sar_pkg;
    typedef enum {VAR_SERIAL8, VAR_EXPAND8, VAR_FULL12} sar_variant_e;
    typedef enum {ST_DONE, ST_CONV} conv_state_e;

    function automatic int width_of(input sar_variant_e v);
        return (v == VAR_FULL12) ? `SAR_WIDTH_LONG : `SAR_WIDTH_SHORT;
    endfunction
endpackage

// >>> core/sar_stream_if.sv
// Valid/ready word stream between the register and its output buffer
`timescale 1ns/1ps
`default_nettype none
interface sar_stream_if #(parameter int W = 12);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> core/sar_word_buffer.sv
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"
module sar_word_buffer
    import sar_pkg::*;
#(
    parameter int W = `SAR_WIDTH_LONG
) (
    input  wire logic    ref_clk_in,
    input  wire logic    arst_n_in,
    sar_stream_if.sink   push,
    sar_stream_if.source pop
);
    localparam int PW = $clog2(`SAR_BUF_DEPTH);
    localparam int CW = $clog2(`SAR_BUF_DEPTH + 1);

    logic [W-1:0]  mem      [`SAR_BUF_DEPTH];
    logic [W-1:0]  next_mem [`SAR_BUF_DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic          do_push;
    logic          do_pop;

    assign push.ready = (count != CW'(`SAR_BUF_DEPTH));
    assign pop.valid  = (count != '0);
    assign pop.data   = mem[rd_ptr];

    always_comb begin
        do_push     = push.valid && push.ready;
        do_pop      = pop.valid && pop.ready;
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (do_push) begin
            next_mem[wr_ptr] = push.data;
            next_wr_ptr      = wr_ptr + PW'(1);
        end
        if (do_pop) begin
            next_rd_ptr = rd_ptr + PW'(1);
        end
        // Simultaneous push and pop leaves the fill level alone
        if (do_push && !do_pop) begin
            next_count = count + CW'(1);
        end else if (do_pop && !do_push) begin
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < `SAR_BUF_DEPTH; i++) begin
                mem[i] <= '0;
            end
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            mem    <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end
endmodule
`default_nettype wire

// >>> core/successive_approx_register.sv
// Successive-approximation control register with buffered result stream
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"
module successive_approx_register
    import sar_pkg::*;
#(
    parameter sar_variant_e VARIANT = VAR_FULL12,
    localparam int          W       = width_of(VARIANT)
) (
    input  wire logic         ref_clk_in,
    input  wire logic         arst_n_in,
    input  wire logic         start_n_in,
    input  wire logic         data_in,
    input  wire logic         expand_n_in,
    output logic [W-1:0]      result_out,
    output logic              top_bit_out,
    output logic              top_bit_n_out,
    output logic              bottom_bit_out,
    output logic              serial_out,
    output logic              finish_n_out,
    output logic [W-1:0]      word_data_out,
    output logic              word_valid_out,
    input  wire logic         word_ready_in
);
    localparam int   IW         = $clog2(W);
    localparam logic HAS_EXPAND = (VARIANT != VAR_SERIAL8);
    localparam logic HAS_SERIAL = (VARIANT != VAR_EXPAND8);

    // Pin synchroniser
    logic [`SAR_PIN_COUNT-1:0] pin_meta;
    logic [`SAR_PIN_COUNT-1:0] pin_sync;
    logic [`SAR_PIN_COUNT-1:0] next_pin_meta;

    always_comb begin
        next_pin_meta = {expand_n_in, data_in, start_n_in};
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_meta <= `SAR_PIN_IDLE;
            pin_sync <= `SAR_PIN_IDLE;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= pin_meta;
        end
    end

    // Master stage on the falling edge
    logic m_start_n;
    logic m_data;
    logic m_expand_n;
    logic next_m_start_n;
    logic next_m_data;
    logic next_m_expand_n;

    always_comb begin
        next_m_start_n  = pin_sync[`SAR_PIN_START];
        next_m_data     = pin_sync[`SAR_PIN_DATA];
        // Expansion pin is absent on the serial 8-bit variant
        next_m_expand_n = HAS_EXPAND ? pin_sync[`SAR_PIN_EXPAND] : 1'b0;
    end

    // Half-cycle apart stages stand in for the non-overlapping phases
    always_ff @(negedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            m_start_n  <= 1'b1;
            m_data     <= 1'b0;
            m_expand_n <= 1'b0;
        end else begin
            m_start_n  <= next_m_start_n;
            m_data     <= next_m_data;
            m_expand_n <= next_m_expand_n;
        end
    end

    // Slave stage on the rising edge
    conv_state_e   state;
    conv_state_e   next_state;
    logic [IW-1:0] idx;
    logic [IW-1:0] next_idx;
    logic [W-1:0]  bits;
    logic [W-1:0]  next_bits;
    logic [W-1:0]  par;
    logic [W-1:0]  next_par;
    logic          serial;
    logic          next_serial;
    logic          finish_n;
    logic          next_finish_n;
    logic          expand_hold;
    logic          at_bottom;
    logic          buf_ready;

    sar_stream_if #(.W(W)) push_if ();
    sar_stream_if #(.W(W)) pop_if ();

    assign expand_hold = m_expand_n;
    assign at_bottom   = (idx == IW'(`SAR_BOTTOM));
    assign buf_ready   = push_if.ready;

    // Last bit waits while the buffer is full, so no word is dropped
    assign push_if.valid = m_start_n && (state == ST_CONV) && !expand_hold && at_bottom;
    assign push_if.data  = {bits[W-1:1], m_data};

    always_comb begin
        next_state    = state;
        next_idx      = idx;
        next_bits     = bits;
        next_finish_n = finish_n;
        if (!m_start_n) begin
            next_bits     = {1'b0, {(W-1){1'b1}}};
            next_idx      = IW'(W - 1);
            next_state    = ST_CONV;
            next_finish_n = 1'b1;
        end else if (state == ST_CONV && !expand_hold) begin
            if (at_bottom) begin
                if (buf_ready) begin
                    next_bits[idx] = m_data;
                    next_state     = ST_DONE;
                    next_finish_n  = 1'b0;
                end
            end else begin
                next_bits[idx]            = m_data;
                next_bits[idx - IW'(1)]   = 1'b0;
                next_idx                  = idx - IW'(1);
            end
        end
        next_par         = next_bits;
        next_par[W-1]    = next_bits[W-1] | expand_hold;
        next_serial      = HAS_SERIAL ? m_data : 1'b0;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state    <= ST_DONE;
            idx      <= '0;
            bits     <= '1;
            par      <= '1;
            serial   <= 1'b0;
            finish_n <= 1'b0;
        end else begin
            state    <= next_state;
            idx      <= next_idx;
            bits     <= next_bits;
            par      <= next_par;
            serial   <= next_serial;
            finish_n <= next_finish_n;
        end
    end

    sar_word_buffer #(.W(W)) word_buffer (
        .ref_clk_in (ref_clk_in),
        .arst_n_in  (arst_n_in),
        .push       (push_if.sink),
        .pop        (pop_if.source)
    );

    assign pop_if.ready   = word_ready_in;
    assign word_data_out  = pop_if.data;
    assign word_valid_out = pop_if.valid;

    assign result_out     = par;
    assign top_bit_out    = par[W-1];
    assign top_bit_n_out  = ~par[W-1];
    assign bottom_bit_out = par[`SAR_BOTTOM];
    assign serial_out     = serial;
    assign finish_n_out   = finish_n;

    // Checks
    start_load_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        !m_start_n |=> (bits == {1'b0, {(W-1){1'b1}}}) && (idx == IW'(W - 1)))
        else $error("start did not load the trial pattern");

    finish_set_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        !m_start_n |=> finish_n_out && state == ST_CONV)
        else $error("start did not raise conversion complete");

    capture_bit_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (m_start_n && state == ST_CONV && !expand_hold && !at_bottom)
        |=> bits[$past(idx)] == $past(m_data))
        else $error("data not stored into trial bit");

    next_low_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (m_start_n && state == ST_CONV && !expand_hold && !at_bottom)
        |=> !bits[$past(idx) - IW'(1)] && idx == $past(idx) - IW'(1))
        else $error("next bit not pulled low");

    first_step_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (!m_start_n ##1 (m_start_n && !expand_hold))
        |=> result_out[W-1] == $past(m_data) && !result_out[W-2])
        else $error("first step after start wrong");

    done_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (state == ST_DONE && m_start_n && !expand_hold) ##1 (m_start_n && !expand_hold)
        |=> $stable(result_out) && !finish_n_out)
        else $error("outputs moved after completion");

    finish_span_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        finish_n_out == (state == ST_CONV))
        else $error("conversion complete does not track conversion");

    expand_top_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (expand_hold && m_start_n) |=> top_bit_out && $stable(idx) && $stable(finish_n_out))
        else $error("expansion hold not honoured");

    serial_delay_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        HAS_SERIAL |-> ##1 serial_out == $past(m_data))
        else $error("serial output not one period late");

    complement_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        top_bit_n_out != top_bit_out)
        else $error("complement output wrong");
endmodule
`default_nettype wire

// >>> testbench/sar_ladder_model.sv
// Comparator and ladder model feeding the register's data input
`timescale 1ns/1ps
`default_nettype none
module sar_ladder_model #(
    parameter int W = 12
) (
    input  wire logic         clk_in,
    input  wire logic         start_n_in,
    input  wire logic [W-1:0] target_in,
    output var  logic         data_out
);
    int idx = -1;

    initial data_out = 1'b0;

    // Bits run two cycles ahead, since the register resamples its data pin
    always @(negedge clk_in) begin
        if (start_n_in === 1'b0) begin
            idx = W - 1;
        end
        if (idx >= 0) begin
            // Ladder switch is on when low, so a kept bit reads low
            data_out <= ~target_in[idx];
            idx = idx - 1;
        end
        // Afterwards the ladder is steady, so the comparator holds its level
    end
endmodule
`default_nettype wire

// >>> testbench/successive_approx_register_tb.sv
// Self-checking bench for the successive-approximation register
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH %0t %s", $time, m); end end
module successive_approx_register_tb
    import sar_pkg::*;
;
    localparam int W = `SAR_WIDTH_LONG;
    localparam logic [W-1:0] RELOAD = {1'b0, {(W-1){1'b1}}};
    logic         clk      = 1'b0;
    logic         arst_n   = 1'b0;
    logic         start_n  = 1'b1;
    logic         expand_n = 1'b0;
    logic         ready    = 1'b1;
    logic [W-1:0] target   = '0;
    logic [W-1:0] result, word, last;
    logic         data, top, top_n, bottom, serial, finish_n, valid;
    logic [W-1:0] exp_q[$];
    int           n_mismatch   = 0;
    int           total_checks = 0;
    int           n;

    always #10 clk = ~clk;

    successive_approx_register #(.VARIANT(VAR_FULL12)) successive_approx_register_i (
        .ref_clk_in(clk), .arst_n_in(arst_n), .start_n_in(start_n), .data_in(data),
        .expand_n_in(expand_n), .result_out(result), .top_bit_out(top),
        .top_bit_n_out(top_n), .bottom_bit_out(bottom), .serial_out(serial),
        .finish_n_out(finish_n), .word_data_out(word), .word_valid_out(valid),
        .word_ready_in(ready));

    sar_ladder_model #(.W(W)) sar_ladder_model_i (
        .clk_in(clk), .start_n_in(start_n), .target_in(target), .data_out(data));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic fail_wait(input string m);
        n_mismatch++;
        $display("MISMATCH %0t %s", $time, m);
        report_and_stop();
    endtask

    // Words leave in order of completion; looked at before the rising edge, once settled
    always @(negedge clk) begin
        #5;
        if (valid === 1'b1 && ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(1'b1, 1'b0, "unexpected word")
            end else begin
                `CHK(word, exp_q.pop_front(), "word")
            end
        end
    end

    task automatic convert(input logic [W-1:0] tgt, input int steps);
        logic [W-1:0] e;
        @(negedge clk);
        target <= tgt;
        start_n <= 1'b0;
        @(negedge clk);
        start_n <= 1'b1;
        repeat (2) @(negedge clk);
        `CHK(result, RELOAD, "reload")
        `CHK(finish_n, 1'b1, "finish on start")
        e = RELOAD;
        if (steps == W) begin
            exp_q.push_back(~tgt);
        end
        for (int i = 1; i <= steps; i++) begin
            @(negedge clk);
            e[W-i] = ~tgt[W-i];
            if (i < W) begin
                e[W-i-1] = 1'b0;
            end
            `CHK(result, e, "register")
            `CHK({top, bottom}, {e[W-1], e[0]}, "ends")
            `CHK(serial, ~tgt[W-i], "serial")
            `CHK(finish_n, i < W, "finish")
            `CHK(top_n, ~e[W-1], "complement")
        end
    endtask

    initial begin
        void'($urandom(32'h04cc3c49));
        repeat (8) @(negedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            convert(W'($urandom()), W);
        end
        convert('0, W);
        convert('1, W);
        $display("test basic done");
        convert(W'($urandom()), 5);
        convert(W'($urandom()), W);
        $display("test restart done");
        last = result;
        expand_n <= 1'b1;
        repeat (5) @(negedge clk);
        `CHK(top, 1'b1, "forced top")
        `CHK(result[W-2:0], last[W-2:0], "held bits")
        `CHK(finish_n, 1'b0, "held finish")
        expand_n <= 1'b0;
        repeat (5) @(negedge clk);
        `CHK(result, last, "restored")
        // Start while expansion holds: reload shows with the top bit forced high, but no bit is taken
        expand_n <= 1'b1;
        start_n  <= 1'b0;
        @(negedge clk);
        start_n  <= 1'b1;
        repeat (6) @(negedge clk);
        `CHK(result, {W{1'b1}}, "held trial")
        `CHK(finish_n, 1'b1, "held busy")
        expand_n <= 1'b0;
        $display("test expansion done");
        ready <= 1'b0;
        convert(W'($urandom()), W);
        convert(W'($urandom()), W);
        last = W'($urandom());
        convert(last, W - 1);
        repeat (3) @(negedge clk);
        // Full buffer must hold off the final bit
        `CHK(finish_n, 1'b1, "stalled")
        exp_q.push_back(~last);
        n = 0;
        while (finish_n !== 1'b0 && n < 40) begin
            ready <= 1'($urandom());
            @(negedge clk);
            n++;
        end
        if (n == 40) fail_wait("stall never ended");
        `CHK(result, ~last, "after stall")
        n = 0;
        while (exp_q.size() > 0 && n < 100) begin
            ready <= 1'($urandom());
            @(negedge clk);
            n++;
        end
        if (n == 100) fail_wait("buffer never drained");
        ready <= 1'b1;
        @(negedge clk);
        `CHK(valid, 1'b0, "empty")
        $display("test backpressure done");
        arst_n <= 1'b0;
        @(negedge clk);
        `CHK({result, finish_n, serial, valid}, {{W{1'b1}}, 3'b000}, "in reset")
        arst_n <= 1'b1;
        convert(W'($urandom()), W);
        repeat (3) @(negedge clk);
        `CHK(exp_q.size(), 0, "word after reset")
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
